// *** rtl/ice_cfg.svh ***
/*
 Constants of the indexer command executor: character codes, command
 words, limits and buffer sizing. Assumes ASCII text on the serial link.
*/
`ifndef ICE_CFG_SVH
`define ICE_CFG_SVH
// ==========================================================
// Characters
`define ICE_CH_CR 8'h0d
`define ICE_CH_COMMA 8'h2c
`define ICE_CH_DOT 8'h2e
`define ICE_CH_0 8'h30
`define ICE_CH_9 8'h39
`define ICE_CH_UA 8'h41
`define ICE_CH_UZ 8'h5a
`define ICE_CH_LA 8'h61
`define ICE_CH_LZ 8'h7a
`define ICE_CASE_BIT 8'h20
// ==========================================================
// Command words, last five letters, right aligned
`define ICE_W_TUNE 40'h0054554e45
`define ICE_W_GAIN 40'h4741494e58
`define ICE_W_SAVE 40'h0000005356
`define ICE_W_PAUSE 40'h0000000055
`define ICE_W_CONT 40'h0000000043
`define ICE_W_VEL 40'h0000000056
`define ICE_W_CMODE 40'h0000004d43
`define ICE_W_NMODE 40'h0000004d4e
`define ICE_W_GO 40'h0000000047
`define ICE_W_REPORT 40'h0000000057
`define ICE_REPORT_SEL 16'h0001
// ==========================================================
// Limits, velocity in hundredths of a rev per second
`define ICE_VEL_MAX 24'h001770
`define ICE_VEL_DEF 14'h0064
`define ICE_TUNE_HOP 10'h200
`define ICE_TUNE_RES 14'h3200
`define ICE_TUNE_M_MAX 16'h0003
`define ICE_TUNE_O_MAX 16'h0004
`define ICE_BUF_DEPTH 8
`define ICE_BUF_AW 3
`define ICE_REPORT_BYTES 3'h4
`endif

// *** rtl/ice_pkg.sv ***
/*
 Types of the indexer command executor. Assumes ice_cfg.svh beside it.
*/
`include "ice_cfg.svh"
package ice_pkg;
  // ========================================================
  // Commands
  typedef enum logic [3:0] {ICE_CMD_NONE, ICE_CMD_TUNE, ICE_CMD_GAIN,
    ICE_CMD_SAVE, ICE_CMD_PAUSE, ICE_CMD_CONT, ICE_CMD_VEL, ICE_CMD_CMODE,
    ICE_CMD_NMODE, ICE_CMD_GO, ICE_CMD_REPORT} ice_cmd_e;
  typedef struct packed {
    ice_cmd_e code;
    logic [13:0] value;
  } ice_entry_s;
  // ========================================================
  // Decoder state
  typedef struct packed {
    logic [39:0] word;
    logic [15:0] addr;
    logic addr_given;
    logic seen_letter;
    logic [15:0] p1;
    logic [1:0] frac;
    logic dot;
    logic in_p2;
    logic [15:0] p2;
    logic out_valid;
    ice_cmd_e out_code;
    logic [15:0] out_p1;
    logic [1:0] out_frac;
    logic [15:0] out_p2;
  } ice_dec_s;
  // ========================================================
  // Executor state
  typedef struct packed {
    ice_entry_s [`ICE_BUF_DEPTH-1:0] buffer;
    logic [`ICE_BUF_AW-1:0] wr;
    logic [`ICE_BUF_AW-1:0] rd;
    logic [`ICE_BUF_AW:0] cnt;
    logic paused;
    logic waiting;
    logic wait_speed;
    logic reached;
    logic [13:0] vel;
    logic cont_mode;
    logic move_start;
    logic [13:0] move_vel;
    logic moving;
    logic tri_profile;
    logic gain_sel;
    logic tune_start;
    logic [1:0] tune_move;
    logic [2:0] tune_perf;
    logic [9:0] tune_hop;
    logic nv_save;
    logic [31:0] pos;
    logic [31:0] shot;
    logic [2:0] tx_left;
    logic tx_valid;
    logic [7:0] tx_byte;
  } ice_exe_s;
endpackage

// *** rtl/ice_cmd_if.sv ***
/*
 Decoded command channel from the text decoder to the executor.
 Assumes both ends share one clock; valid is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface ice_cmd_if;
  import ice_pkg::*;
  logic valid;
  ice_cmd_e code;
  logic [15:0] p1;
  logic [1:0] frac;
  logic [15:0] p2;
  modport dec (output valid, output code, output p1, output frac,
    output p2);
  modport exe (input valid, input code, input p1, input frac, input p2);
endinterface

// *** rtl/ice_text_dec.sv ***
/*
 Text decoder: turns received characters into decoded commands.
 Assumes bytes arrive already deserialised, on the same clock.
*/
`timescale 1ns/1ps
`include "ice_cfg.svh"
module ice_text_dec
  import ice_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire logic rx_valid, // Character strobe
  input wire logic [7:0] rx_byte, // Character
  input wire logic [7:0] unit_addr, // Own unit address
  ice_cmd_if.dec cmd // Decoded command out
);
  ice_dec_s s_r;
  ice_dec_s s_nxt;
  logic [7:0] ch;
  logic [15:0] dig;
  ice_cmd_e found;

  // ========================================================
  // Word lookup, lower case folded beforehand
  always_comb
  begin
    ch = rx_byte;
    if (rx_byte >= `ICE_CH_LA && rx_byte <= `ICE_CH_LZ)
      ch = rx_byte & ~`ICE_CASE_BIT;
    dig = {8'h00, rx_byte - `ICE_CH_0};
    case (s_r.word)
      `ICE_W_TUNE: found = ICE_CMD_TUNE;
      `ICE_W_GAIN: found = ICE_CMD_GAIN;
      `ICE_W_SAVE: found = ICE_CMD_SAVE;
      `ICE_W_PAUSE: found = ICE_CMD_PAUSE;
      `ICE_W_CONT: found = ICE_CMD_CONT;
      `ICE_W_VEL: found = ICE_CMD_VEL;
      `ICE_W_CMODE: found = ICE_CMD_CMODE;
      `ICE_W_NMODE: found = ICE_CMD_NMODE;
      `ICE_W_GO: found = ICE_CMD_GO;
      `ICE_W_REPORT: found = (s_r.p1 == `ICE_REPORT_SEL) ?
        ICE_CMD_REPORT : ICE_CMD_NONE;
      default: found = ICE_CMD_NONE;
    endcase
  end

  // ========================================================
  // Character parser; nothing issues before the carriage return
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.out_valid = 1'b0;
    if (rx_valid)
    begin
      if (rx_byte == `ICE_CH_CR)
      begin
        // Foreign address: swallow, the unit it names will answer
        s_nxt.out_valid = s_r.seen_letter && (found != ICE_CMD_NONE) &&
          (!s_r.addr_given || s_r.addr == {8'h00, unit_addr}); // [R16]
        s_nxt.out_code = found;
        s_nxt.out_p1 = s_r.p1;
        s_nxt.out_frac = s_r.frac;
        s_nxt.out_p2 = s_r.p2;
        s_nxt.word = '0;
        s_nxt.addr = '0;
        s_nxt.addr_given = 1'b0;
        s_nxt.seen_letter = 1'b0;
        s_nxt.p1 = '0;
        s_nxt.p2 = '0;
        s_nxt.frac = '0;
        s_nxt.dot = 1'b0;
        s_nxt.in_p2 = 1'b0;
      end
      else if (ch >= `ICE_CH_UA && ch <= `ICE_CH_UZ)
      begin
        s_nxt.seen_letter = 1'b1;
        s_nxt.word = {s_r.word[31:0], ch};
      end
      else if (rx_byte >= `ICE_CH_0 && rx_byte <= `ICE_CH_9)
      begin
        if (!s_r.seen_letter)
        begin
          s_nxt.addr_given = 1'b1;
          s_nxt.addr = 16'(s_r.addr * 16'h000a + dig);
        end
        else if (s_r.in_p2)
          s_nxt.p2 = 16'(s_r.p2 * 16'h000a + dig);
        else if (!s_r.dot || s_r.frac != 2'h2)
        begin
          // Digits past the hundredths are dropped
          s_nxt.p1 = 16'(s_r.p1 * 16'h000a + dig);
          if (s_r.dot)
            s_nxt.frac = s_r.frac + 2'h1;
        end
      end
      else if (rx_byte == `ICE_CH_COMMA)
        s_nxt.in_p2 = 1'b1;
      else if (rx_byte == `ICE_CH_DOT)
        s_nxt.dot = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign cmd.valid = s_r.out_valid;
  assign cmd.code = s_r.out_code;
  assign cmd.p1 = s_r.out_p1;
  assign cmd.frac = s_r.out_frac;
  assign cmd.p2 = s_r.out_p2;

  // ========================================================
  // Checks
  a_cmd_after_cr: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    s_r.out_valid |-> $past(rx_valid && rx_byte == `ICE_CH_CR))
    else $error("command issued without carriage return");
endmodule

// *** rtl/ice_exec.sv ***
/*
 Indexer command executor: command buffer, pause and continue, move
 mode gating, velocity, self-tune setup, gain set choice, save strobe and
 the binary position report. Assumes the motion generator, step feedback
 and serial transmitter run on the same clock.
*/
`timescale 1ns/1ps
`include "ice_cfg.svh"
// Function
// R01: Tune move 1 to-and-fro, 2 clockwise, 3 anticlockwise, 512-step hops.
// R02: Tune performance option 1 to 4 selects the closed-loop character.
// R03: Tuned and user gain sets kept apart; switch command picks one.
// R04: Save command stores the self-tuned gains into non-volatile memory.
// R05: Pause lets the current command finish, then stops further processing.
// R06: Buffer kept while paused; continue resumes exactly where it stopped.
// R07: Velocity 0.00 to 60.00 rps, default 1, buffered, used by go.
// R08: Move too short for set speed gives a triangular profile.
// R09: Continuous mode: next buffered command waits for set speed.
// R10: Normal mode: next buffered command waits for move completion.
// R11: Report gives steps since motion start, or last move when stopped.
// R12: Report is four bytes, one 32-bit value, most significant first.
// R13: Report is two's complement; negative moves set bit 31.
// R14: Report carries no leading asterisk, for fastest response.
// R15: Host never asks for the report on a daisy-chained link.
// R16: Commands are addressed ASCII text ended by carriage return.
module ice_exec
  import ice_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst_n, // Async reset, low
  input wire logic rx_valid, // Received character strobe
  input wire logic [7:0] rx_byte, // Received character
  input wire logic [7:0] unit_addr, // Own unit address
  input wire logic step_pulse, // One step travelled
  input wire logic step_neg, // Step is in the negative direction
  input wire logic at_speed, // Motor has reached set speed
  input wire logic move_done, // Move fully completed
  input wire logic tx_ready, // Transmitter takes tx_byte
  output logic tx_valid, // Report byte valid
  output logic [7:0] tx_byte, // Report byte
  output logic move_start, // Go pulse to the motion generator
  output logic [13:0] move_vel, // Peak speed, 0.01 rps units
  output logic cont_mode, // Continuous move mode active
  output logic paused, // Execution suspended
  output logic tri_profile, // Last move ended below set speed
  output logic gain_sel, // 1: self-tuned set, 0: user set
  output logic tune_start, // Self-tune start pulse
  output logic [1:0] tune_move, // Tune move type
  output logic [2:0] tune_perf, // Tune performance option
  output logic [9:0] tune_hop, // Tune hop length in steps
  output logic nv_save // Save-to-memory pulse
);
  ice_exe_s s_r;
  ice_exe_s s_nxt;
  ice_cmd_if cmd ();
  ice_entry_s head;
  ice_entry_s entry;
  logic [23:0] vel_scaled;
  logic push;
  logic pop;
  logic report_go;
  logic [15:0] tm;
  logic [15:0] to;

  ice_text_dec u_dec (
    .clk(clk),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .unit_addr(unit_addr),
    .cmd(cmd)
  );

  // ========================================================
  // Command sorting; a zero tune field means its default of 1
  always_comb
  begin
    head = s_r.buffer[s_r.rd];
    case (cmd.frac)
      2'h0: vel_scaled = 24'(cmd.p1 * 24'h000064);
      2'h1: vel_scaled = 24'(cmd.p1 * 24'h00000a);
      default: vel_scaled = {8'h00, cmd.p1};
    endcase
    tm = (cmd.p1 == 16'h0000) ? 16'h0001 : cmd.p1;
    to = (cmd.p2 == 16'h0000) ? 16'h0001 : cmd.p2;
    entry.code = cmd.code;
    entry.value = vel_scaled[13:0];
    // Out-of-range speeds are dropped rather than clipped
    push = cmd.valid && s_r.cnt != (`ICE_BUF_AW+1)'(`ICE_BUF_DEPTH) &&
      ((cmd.code == ICE_CMD_VEL && vel_scaled <= `ICE_VEL_MAX) || // [R07]
      cmd.code == ICE_CMD_CMODE || cmd.code == ICE_CMD_NMODE ||
      cmd.code == ICE_CMD_GO);
    pop = !s_r.paused && !s_r.waiting && s_r.cnt != '0; // [R05] [R06]
    report_go = cmd.valid && cmd.code == ICE_CMD_REPORT &&
      s_r.tx_left == '0 && !s_r.tx_valid;
  end

  // ========================================================
  // Executor
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.move_start = 1'b0;
    s_nxt.tune_start = 1'b0;
    s_nxt.nv_save = 1'b0;
    // Move tracking and hold-off release
    if (at_speed && s_r.moving)
      s_nxt.reached = 1'b1;
    if (move_done && s_r.moving)
    begin
      s_nxt.moving = 1'b0;
      s_nxt.tri_profile = !(s_r.reached || at_speed); // [R08]
    end
    if (s_r.waiting && (move_done || (s_r.wait_speed && at_speed)))
      s_nxt.waiting = 1'b0; // [R09] [R10]
    // Step count; it stands after the move as its distance
    if (step_pulse)
      s_nxt.pos = step_neg ? s_r.pos - 32'h1 : s_r.pos + 32'h1; // [R11] [R13]
    // Buffer head
    if (pop)
    begin
      s_nxt.rd = s_r.rd + 1'b1;
      case (head.code)
        ICE_CMD_VEL: s_nxt.vel = head.value; // [R07]
        ICE_CMD_CMODE: s_nxt.cont_mode = 1'b1;
        ICE_CMD_NMODE: s_nxt.cont_mode = 1'b0;
        ICE_CMD_GO:
        begin
          s_nxt.move_start = 1'b1;
          s_nxt.move_vel = s_r.vel;
          s_nxt.moving = 1'b1;
          s_nxt.reached = 1'b0;
          s_nxt.waiting = 1'b1;
          s_nxt.wait_speed = s_r.cont_mode; // [R09] [R10]
          s_nxt.pos = '0; // [R11]
        end
        default: s_nxt.rd = s_r.rd + 1'b1;
      endcase
    end
    if (push)
    begin
      s_nxt.buffer[s_r.wr] = entry;
      s_nxt.wr = s_r.wr + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (`ICE_BUF_AW+1)'(push) - (`ICE_BUF_AW+1)'(pop);
    // Immediate commands
    if (cmd.valid)
    begin
      case (cmd.code)
        ICE_CMD_PAUSE: s_nxt.paused = 1'b1; // [R05]
        ICE_CMD_CONT: s_nxt.paused = 1'b0; // [R06]
        ICE_CMD_GAIN: s_nxt.gain_sel = cmd.p1[0]; // [R03]
        ICE_CMD_SAVE: s_nxt.nv_save = 1'b1; // [R04]
        ICE_CMD_TUNE:
        begin
          if (tm <= `ICE_TUNE_M_MAX && to <= `ICE_TUNE_O_MAX)
          begin
            s_nxt.tune_start = 1'b1;
            s_nxt.tune_move = tm[1:0]; // [R01]
            s_nxt.tune_perf = to[2:0]; // [R02]
            s_nxt.tune_hop = `ICE_TUNE_HOP; // [R01]
          end
        end
        default: s_nxt.paused = s_r.paused;
      endcase
    end
    // Report: four raw bytes, high byte first, nothing in front
    if (s_r.tx_valid && tx_ready)
      s_nxt.tx_valid = 1'b0;
    if (s_r.tx_left != '0 && (!s_r.tx_valid || tx_ready))
    begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_byte = s_r.shot[31:24]; // [R12]
      s_nxt.shot = {s_r.shot[23:0], 8'h00};
      s_nxt.tx_left = s_r.tx_left - 3'h1;
    end
    if (report_go)
    begin
      s_nxt.shot = s_r.pos; // [R11] [R13]
      s_nxt.tx_left = `ICE_REPORT_BYTES; // [R14]
    end
  end

  // State register; only the default speed is non-zero at reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.vel <= `ICE_VEL_DEF; // [R07]
    end
    else
      s_r <= s_nxt;
  end

  assign tx_valid = s_r.tx_valid;
  assign tx_byte = s_r.tx_byte;
  assign move_start = s_r.move_start;
  assign move_vel = s_r.move_vel;
  assign cont_mode = s_r.cont_mode;
  assign paused = s_r.paused;
  assign tri_profile = s_r.tri_profile;
  assign gain_sel = s_r.gain_sel;
  assign tune_start = s_r.tune_start;
  assign tune_move = s_r.tune_move;
  assign tune_perf = s_r.tune_perf;
  assign tune_hop = s_r.tune_hop;
  assign nv_save = s_r.nv_save;

  // ========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_pause_no_go: assert property (s_r.paused |=> !s_r.move_start) // [R05]
    else $error("go issued while paused");
  a_buffer_kept: assert property (s_r.paused && !cmd.valid // [R06]
    |=> s_r.cnt == $past(s_r.cnt) && s_r.rd == $past(s_r.rd))
    else $error("buffer changed while paused");
  a_vel_range: assert property (s_r.move_start // [R07]
    |-> s_r.move_vel <= 14'h1770)
    else $error("go speed out of range");
  a_cont_hold: assert property (s_r.waiting && s_r.wait_speed // [R09]
    && !at_speed && !move_done |=> s_r.waiting ##1 !s_r.move_start)
    else $error("continuous mode released early");
  a_norm_hold: assert property (s_r.waiting && !s_r.wait_speed // [R10]
    && !move_done |=> s_r.waiting ##1 !s_r.move_start)
    else $error("normal mode released early");
  a_pos_from_go: assert property (s_r.move_start |-> s_r.pos == '0) // [R11]
    else $error("step count not cleared at go");
  a_neg_step: assert property (step_pulse && step_neg && !pop // [R13]
    |=> s_r.pos == $past(s_r.pos) - 32'h1)
    else $error("negative step not counted down");
  a_report_msb: assert property (report_go |-> ##2 // [R12]
    (s_r.tx_valid && s_r.tx_byte == $past(s_r.pos[31:24], 2)))
    else $error("report does not open with high byte");
  a_report_len: assert property (report_go // [R14]
    |=> s_r.tx_left == 3'h4 && !s_r.tx_valid)
    else $error("report length wrong");
  a_tune_args: assert property (s_r.tune_start // [R01] [R02]
    |-> s_r.tune_move != 2'h0 && s_r.tune_perf inside {[3'h1:3'h4]})
    else $error("tune started with bad options");

  // Pause spans a full queued sequence, so allow a long window
  c_report: cover property (report_go ##2 s_r.tx_valid);
  c_pause_cont: cover property (s_r.paused ##[1:100] !s_r.paused);
  c_cont_go: cover property (s_r.move_start && s_r.wait_speed);
  c_tri: cover property ($rose(s_r.tri_profile));
endmodule

// *** bench/ice_host_model.sv ***
/*
 Host model: sends text commands and takes report bytes.
 Assumes one clock and a single unit on the serial link.
*/
`timescale 1ns/1ps
module ice_host_model
(
  input wire logic clk, // System clock
  input wire logic slow, // 1: drop ready every other cycle
  output logic rx_valid, // Character strobe
  output logic [7:0] rx_byte, // Character
  input wire logic tx_valid, // Report byte valid
  input wire logic [7:0] tx_byte, // Report byte
  output logic tx_ready // Report byte taken
);
  logic [7:0] got [$];
  logic ph;
  // ========================================================
  // Command sender
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b1;
    ph = 1'b0;
  end
  // Idle byte is inverted so a stale character never looks fresh
  task automatic send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_byte = (i == s.len()) ? 8'h0d : s[i];
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask
  // ========================================================
  // Report taker; single unit only, so reports are safe
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_byte);
    ph <= ~ph;
    tx_ready <= #1 !slow || ph;
  end
endmodule

// *** bench/indexer_command_executor_test.sv ***
/*
 Self-checking bench of the command executor: host model on the
 serial side, motion feedback driven here. Assumes 100 MHz clock.
*/
`timescale 1ns/1ps
module indexer_command_executor_test;
  logic clk, rst_n, rx_valid, step_pulse, step_neg, at_speed;
  logic move_done, tx_ready, tx_valid, move_start, cont_mode;
  logic paused, tri_profile, gain_sel, tune_start, nv_save, slow;
  logic [7:0] rx_byte, tx_byte;
  logic [13:0] move_vel, go_vel;
  logic [1:0] tune_move;
  logic [2:0] tune_perf;
  logic [9:0] tune_hop;
  int err_total, comparisons, n_go, n_tune, n_save, cyc;
  // ========================================================
  // Design and host
  ice_exec dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .unit_addr(8'h01), .step_pulse(step_pulse),
    .step_neg(step_neg), .at_speed(at_speed), .move_done(move_done),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .move_start(move_start), .move_vel(move_vel),
    .cont_mode(cont_mode), .paused(paused), .tri_profile(tri_profile),
    .gain_sel(gain_sel), .tune_start(tune_start), .tune_move(tune_move),
    .tune_perf(tune_perf), .tune_hop(tune_hop), .nv_save(nv_save));
  ice_host_model host (.clk(clk), .slow(slow), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready));
  // Clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse counters; one-cycle pulses are easy to miss otherwise
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (move_start === 1'b1) n_go <= n_go + 1;
  always @(posedge clk) if (move_start === 1'b1) go_vel <= move_vel;
  always @(posedge clk) if (tune_start === 1'b1) n_tune <= n_tune + 1;
  always @(posedge clk) if (nv_save === 1'b1) n_save <= n_save + 1;
  // Hang guard, far above the 1300 or so cycles needed
  always @(posedge clk)
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  // ========================================================
  // Shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a pulse counter to move past base
  task automatic wait_for(ref int c, input int base, input int lim);
    for (int k = 0; k < lim && c == base; k++)
      @(posedge clk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask
  task automatic steps(input int n, input logic neg);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      step_neg = neg;
      step_pulse = 1'b1;
      @(posedge clk);
      #1;
      step_pulse = 1'b0;
    end
  endtask
  task automatic report(input logic [31:0] exp);
    host.got.delete();
    host.send("1W1");
    for (int k = 0; k < 40 && host.got.size() < 4; k++)
      @(posedge clk);
    idle(10);
    chk("report bytes", 32'h4, host.got.size());
    chk("report value", exp, {host.got[0], host.got[1], host.got[2],
      host.got[3]});
  endtask
  // ========================================================
  // Scenarios
  task automatic t_vel();
    int b;
    b = n_go;
    host.send("G");
    wait_for(n_go, b, 20);
    chk("default speed", 32'h64, go_vel);
    pulse(move_done);
    host.send("V61");
    host.send("V12.34");
    host.send("V60.01");
    host.send("G");
    wait_for(n_go, b + 1, 20);
    chk("set speed", 32'h4d2, go_vel);
    pulse(move_done);
  endtask
  task automatic t_normal();
    int b;
    b = n_go;
    host.send("G");
    host.send("G");
    wait_for(n_go, b, 20);
    idle(30);
    chk("held to done", b + 1, n_go);
    pulse(at_speed);
    idle(5);
    chk("held past speed", b + 1, n_go);
    pulse(move_done);
    wait_for(n_go, b + 1, 20);
    chk("next after done", b + 2, n_go);
    chk("trapezoid", 32'h0, tri_profile);
    pulse(move_done);
    idle(3);
    chk("triangle", 32'h1, tri_profile);
  endtask
  task automatic t_cont();
    int b;
    b = n_go;
    host.send("MC");
    host.send("G");
    host.send("G");
    wait_for(n_go, b, 20);
    idle(10);
    chk("continuous", 32'h1, cont_mode);
    chk("held to speed", b + 1, n_go);
    pulse(at_speed);
    wait_for(n_go, b + 1, 20);
    chk("next at speed", b + 2, n_go);
    pulse(move_done);
    host.send("MN");
    idle(5);
    chk("normal", 32'h0, cont_mode);
  endtask
  task automatic t_pause();
    int b;
    b = n_go;
    host.send("G");
    wait_for(n_go, b, 20);
    host.send("U");
    host.send("V3");
    host.send("G");
    idle(3);
    chk("paused", 32'h1, paused);
    pulse(move_done);
    idle(30);
    chk("no pop paused", b + 1, n_go);
    host.send("C");
    wait_for(n_go, b + 1, 20);
    chk("resumed", b + 2, n_go);
    chk("kept speed", 32'h12c, go_vel);
    chk("running", 32'h0, paused);
    pulse(move_done);
  endtask
  task automatic t_tune();
    int b;
    for (int m = 1; m <= 4; m++)
      for (int o = 1; o <= 5; o++)
      begin
        b = n_tune;
        host.send($sformatf("TUNE:%0d,%0d", m, o));
        wait_for(n_tune, b, 8);
        chk("tune taken", (m < 4 && o < 5) ? b + 1 : b, n_tune);
        if (m < 4 && o < 5)
        begin
          chk("tune move", m, tune_move);
          chk("tune perf", o, tune_perf);
          chk("tune hop", 32'h200, tune_hop);
        end
      end
  endtask
  task automatic t_gain();
    int b;
    b = n_save;
    host.send("GAINX1");
    idle(4);
    chk("tuned set", 32'h1, gain_sel);
    host.send("SV");
    wait_for(n_save, b, 8);
    chk("save pulse", b + 1, n_save);
    host.send("GAINX0");
    idle(4);
    chk("user set", 32'h0, gain_sel);
  endtask
  task automatic t_report();
    int b;
    b = n_go;
    host.send("G");
    wait_for(n_go, b, 20);
    steps(300, 1'b0);
    host.got.delete();
    host.send("2W1");
    idle(10);
    chk("other unit", 32'h0, host.got.size());
    slow = 1'b1;
    report(32'h12c);
    slow = 1'b0;
    pulse(move_done);
    report(32'h12c);
    host.send("G");
    wait_for(n_go, b + 1, 20);
    steps(3, 1'b1);
    report(32'hfffffffd);
    pulse(move_done);
  endtask
  // ========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    step_pulse = 1'b0;
    step_neg = 1'b0;
    at_speed = 1'b0;
    move_done = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("reset pause", 32'h0, paused);
    chk("reset report", 32'h0, tx_valid);
    t_vel();
    t_normal();
    t_cont();
    t_pause();
    t_tune();
    t_gain();
    t_report();
    close_out();
  end
endmodule
